// ==== core/swhpc_pkg.sv ====
// constants and types shared by both ends of the switch host port
package swhpc_pkg;
  // ****************************************
  // bus geometry
  // ****************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int STREAMS = 32;
  localparam int STREAM_W = 5;
  localparam int CH_W = 8;
  localparam int IDX_W = STREAM_W + CH_W;
  localparam int BYTE_W = 8;
  // ****************************************
  // device address map
  // ****************************************
  localparam logic [1:0] REGION_CTRL = 2'h0;
  localparam logic [1:0] REGION_DM = 2'h1;
  localparam logic [1:0] REGION_CM = 2'h2;
  localparam logic [IDX_W-1:0] CTRL_OFS = 13'h0000;
  localparam logic [IDX_W-1:0] STAT_OFS = 13'h0001;
  localparam logic [IDX_W-1:0] MEAS_OFS = 13'h0002;
  localparam int CTRL_OSB_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam int STAT_FMT_BIT = 0;
  localparam int STAT_WIDE_BIT = 1;
  localparam int STAT_MEAS_BIT = 2;
  localparam int CM_MODE_HI_BIT = 15;
  localparam int CM_MODE_LO_BIT = 14;
  localparam logic [DATA_W-1:0] CM_RESET = 16'h0000;
  // ****************************************
  // frame pulse detection and timing
  // ****************************************
  localparam logic [4:0] IDLE_RUN = 5'h10;
  localparam int AUX_CLK_KHZ = 4096;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_CYC_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_CYC_RAW < 1) ? 1 : RESET_CYC_RAW;
  // ****************************************
  // host command registers
  // ****************************************
  localparam logic [3:0] HR_ADDR = 4'h0;
  localparam logic [3:0] HR_WDATA = 4'h1;
  localparam logic [3:0] HR_CMD = 4'h2;
  localparam logic [3:0] HR_STAT = 4'h3;
  localparam logic [3:0] HR_RDATA = 4'h4;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_DONE_BIT = 1;
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_ACK = 2'b01,
    DEV_ACK_HI = 2'b10
  } swhpc_dev_st_t;
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_SETUP = 3'b001,
    HST_STROBE = 3'b010,
    HST_END = 3'b011,
    HST_RESET = 3'b100
  } swhpc_hst_st_t;
endpackage : swhpc_pkg

// ==== core/swhpc_bus_if.sv ====
// microprocessor port wires between host and device, with pull-ups resolved
interface swhpc_bus_if;
  logic cs_n;
  logic ds_n;
  logic rw;
  logic [swhpc_pkg::ADDR_W-1:0] addr;
  logic [swhpc_pkg::DATA_W-1:0] host_data;
  logic host_data_oe_n;
  logic [swhpc_pkg::DATA_W-1:0] dev_data;
  logic dev_data_oe_n;
  logic [swhpc_pkg::DATA_W-1:0] host_data_bus;
  logic ack_out;
  logic ack_oe_n;
  logic transfer_ack_n;
  logic reset_n;

  // ****************************************
  // wire level: driver wins, else pull-up
  // ****************************************
  assign host_data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 16'hFFFF);
  assign transfer_ack_n = ack_oe_n ? 1'b1 : ack_out;

  modport dev (
    input cs_n, ds_n, rw, addr, host_data_bus, reset_n,
    output dev_data, dev_data_oe_n, ack_out, ack_oe_n
  );
  modport host (
    output cs_n, ds_n, rw, addr, host_data, host_data_oe_n, reset_n,
    input host_data_bus, transfer_ack_n
  );
endinterface : swhpc_bus_if

// ==== core/swhpc_dev.sv ====
// device end: processor port, output drive control and frame handling
// ****************************************
// Overview of operation
// - select high picks wide pulse alignment
// - shared pin: measure input or alignment clock
// - frame pulse format detected automatically
// - serial clock shifts all 32 streams
// - device reset clears counters and registers, keeps memories, floats outputs
// - host holds reset at least 100ns
// - access only with strobe and select low
// - rw sets direction; device drives reads only
// - host asserts select for any access
// - 15-bit address selects memories or registers
// - data moves over 16-bit bus
// - acknowledge low marks transfer complete
// - cycle end: ack driven high, then released
// - enable low and standby low float outputs
// - enable high drives, channel may still float
// - otherwise channel mode bits decide float
// - both mode bits one float the channel
// ****************************************
module swhpc_dev (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // processor port
  swhpc_bus_if.dev bus,
  // frame and clock pins
  input wire logic serial_clk,
  input wire logic frame_sync_in,
  input wire logic frame_measure_in,
  input wire logic frame_format_select,
  // output drive pin
  input wire logic tx_drive_enable,
  // serial streams
  input wire logic [swhpc_pkg::STREAMS-1:0] serial_in_streams,
  output logic [swhpc_pkg::STREAMS-1:0] serial_out_streams,
  output logic [swhpc_pkg::STREAMS-1:0] serial_out_oe_n,
  // status
  output logic wide_frame_pulse_mode,
  output logic format_detected
);
  localparam int NS = swhpc_pkg::STREAMS;
  localparam int PIN_W = NS + 5;
  localparam int P_CLK = NS;
  localparam int P_FS = NS + 1;
  localparam int P_MS = NS + 2;
  localparam int P_SEL = NS + 3;
  localparam int P_ODE = NS + 4;
  localparam int DEPTH = 1 << swhpc_pkg::IDX_W;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_q;
  logic sclk_prev_q;
  logic ms_prev_q;
  always_ff @(posedge ref_clk) begin
    pin_meta_q <= {tx_drive_enable, frame_format_select, frame_measure_in, frame_sync_in,
                   serial_clk, serial_in_streams};
    pin_q <= pin_meta_q;
    sclk_prev_q <= pin_q[P_CLK];
    ms_prev_q <= pin_q[P_MS];
  end

  wire clr = rst || !bus.reset_n;
  wire ser_tick = pin_q[P_CLK] && !sclk_prev_q;
  wire wide_sel = pin_q[P_SEL];
  wire aux_rise = wide_sel && pin_q[P_MS] && !ms_prev_q;

  // ****************************************
  // frame pulse format detection
  // ****************************************
  logic fs_prev_q;
  logic fmt_q;
  logic [4:0] run_q;
  logic wide_seen_q;
  wire ms_edge = !wide_sel && (pin_q[P_MS] != ms_prev_q) && (pin_q[P_MS] == fmt_q);
  wire [4:0] run_inc = (run_q == swhpc_pkg::IDLE_RUN) ? run_q : run_q + 5'h01;
  wire fs_lvl = pin_q[P_FS];
  wire std_start = ser_tick && (fs_lvl != fs_prev_q) && (fs_lvl == fmt_q);
  wire wide_start = aux_rise && fs_lvl && !wide_seen_q;
  wire frame_start = wide_sel ? wide_start : std_start;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      fs_prev_q <= 1'b1;
      fmt_q <= 1'b0;
      run_q <= 5'h00;
      wide_seen_q <= 1'b0;
    end else begin
      if (ser_tick) begin
        fs_prev_q <= fs_lvl;
        run_q <= (fs_lvl != fs_prev_q) ? 5'h00 : run_inc;
        if (run_q == swhpc_pkg::IDLE_RUN) begin
          fmt_q <= !fs_lvl;
        end
      end
      wide_seen_q <= fs_lvl && (wide_seen_q || aux_rise);
    end
  end

  // ****************************************
  // bit and channel counters
  // ****************************************
  logic [2:0] bit_q;
  logic [swhpc_pkg::CH_W-1:0] chan_q;
  always_ff @(posedge ref_clk) begin
    if (clr || frame_start) begin
      bit_q <= 3'h0;
      chan_q <= '0;
    end else if (ser_tick) begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        chan_q <= chan_q + 8'h01;
      end
    end
  end

  // ****************************************
  // memories and registers
  // ****************************************
  logic [swhpc_pkg::DATA_W-1:0] cm_q [DEPTH];
  logic [swhpc_pkg::BYTE_W-1:0] dm_q [DEPTH];
  logic [swhpc_pkg::BYTE_W-1:0] rx_sh_q [NS];
  logic [swhpc_pkg::DATA_W-1:0] ctrl_q;
  logic [swhpc_pkg::DATA_W-1:0] meas_q;
  logic meas_valid_q;
  logic output_standby_bit;
  assign output_standby_bit = ctrl_q[swhpc_pkg::CTRL_OSB_BIT];

  // ****************************************
  // processor port decode
  // ****************************************
  swhpc_pkg::swhpc_dev_st_t st_q;
  wire access = !bus.cs_n && !bus.ds_n;
  wire [1:0] region = bus.addr[swhpc_pkg::ADDR_W-1:swhpc_pkg::IDX_W];
  wire [swhpc_pkg::IDX_W-1:0] idx = bus.addr[swhpc_pkg::IDX_W-1:0];
  wire take = (st_q == swhpc_pkg::DEV_IDLE) && access;
  wire do_wr = take && !bus.rw;
  wire do_rd = take && bus.rw;
  wire wr_cm = do_wr && (region == swhpc_pkg::REGION_CM);
  wire wr_ctrl = do_wr && (region == swhpc_pkg::REGION_CTRL) && (idx == swhpc_pkg::CTRL_OFS);
  wire rd_meas = do_rd && (region == swhpc_pkg::REGION_CTRL) && (idx == swhpc_pkg::MEAS_OFS);
  wire [swhpc_pkg::DATA_W-1:0] stat_word = {13'h0000, meas_valid_q, wide_sel, fmt_q};
  wire [swhpc_pkg::DATA_W-1:0] reg_word = (idx == swhpc_pkg::CTRL_OFS) ? ctrl_q :
                                          (idx == swhpc_pkg::STAT_OFS) ? stat_word :
                                          (idx == swhpc_pkg::MEAS_OFS) ? meas_q : 16'h0000;
  wire [swhpc_pkg::DATA_W-1:0] rd_word = (region == swhpc_pkg::REGION_CM) ? cm_q[idx] :
                                         (region == swhpc_pkg::REGION_DM) ? {8'h00, dm_q[idx]} :
                                         (region == swhpc_pkg::REGION_CTRL) ? reg_word : 16'h0000;

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      st_q <= swhpc_pkg::DEV_IDLE;
      bus.dev_data <= 16'h0000;
      bus.dev_data_oe_n <= 1'b1;
      bus.ack_out <= 1'b1;
      bus.ack_oe_n <= 1'b1;
    end else begin
      unique case (st_q)
        swhpc_pkg::DEV_IDLE: begin
          if (access) begin
            st_q <= swhpc_pkg::DEV_ACK;
            bus.ack_out <= 1'b0;
            bus.ack_oe_n <= 1'b0;
            bus.dev_data <= rd_word;
            bus.dev_data_oe_n <= !bus.rw;
          end
        end
        swhpc_pkg::DEV_ACK: begin
          if (!access) begin
            st_q <= swhpc_pkg::DEV_ACK_HI;
            bus.ack_out <= 1'b1;
            bus.dev_data_oe_n <= 1'b1;
          end
        end
        swhpc_pkg::DEV_ACK_HI: begin
          st_q <= swhpc_pkg::DEV_IDLE;
          bus.ack_oe_n <= 1'b1;
        end
        default: begin
          st_q <= swhpc_pkg::DEV_IDLE;
          bus.ack_oe_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ctrl_q <= swhpc_pkg::CTRL_RESET;
      meas_q <= 16'h0000;
      meas_valid_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus.host_data_bus;
      end
      if (ms_edge) begin
        meas_q <= {5'h00, chan_q, bit_q};
      end
      meas_valid_q <= ms_edge || (meas_valid_q && !rd_meas);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_cm) begin
      cm_q[idx] <= bus.host_data_bus;
    end
  end

  // ****************************************
  // receive: shift and store bytes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (ser_tick && bit_q == 3'h7) begin
      for (int s = 0; s < NS; s++) begin
        dm_q[{chan_q, 5'(s)}] <= {rx_sh_q[s][6:0], pin_q[s]};
      end
    end
  end

  // ****************************************
  // per stream shift and drive control
  // ****************************************
  for (genvar g = 0; g < NS; g++) begin : g_stream
    wire [swhpc_pkg::IDX_W-1:0] cm_idx = {chan_q, 5'(g)};
    wire [swhpc_pkg::DATA_W-1:0] cm_word = cm_q[cm_idx];
    wire both_mode = cm_word[swhpc_pkg::CM_MODE_HI_BIT] && cm_word[swhpc_pkg::CM_MODE_LO_BIT];
    wire all_off = !pin_q[P_ODE] && !output_standby_bit;
    always_ff @(posedge ref_clk) begin
      if (clr) begin
        rx_sh_q[g] <= 8'h00;
        serial_out_streams[g] <= 1'b1;
        serial_out_oe_n[g] <= 1'b1;
      end else begin
        if (ser_tick) begin
          rx_sh_q[g] <= {rx_sh_q[g][6:0], pin_q[g]};
          serial_out_streams[g] <= cm_word[3'h7 - bit_q];
        end
        serial_out_oe_n[g] <= all_off || both_mode;
      end
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      wide_frame_pulse_mode <= 1'b0;
      format_detected <= 1'b0;
    end else begin
      wide_frame_pulse_mode <= wide_sel;
      format_detected <= fmt_q;
    end
  end
endmodule : swhpc_dev

// ==== core/swhpc_host.sv ====
// host end: drives the strobe bus on orders from a local register port
module swhpc_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command register port
  input wire logic [3:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  // processor port
  swhpc_bus_if.host bus
);
  // ****************************************
  // command registers
  // ****************************************
  swhpc_pkg::swhpc_hst_st_t st_q;
  logic [swhpc_pkg::ADDR_W-1:0] tgt_q;
  logic [swhpc_pkg::DATA_W-1:0] wdata_q;
  logic [swhpc_pkg::DATA_W-1:0] rdata_q;
  logic done_q;
  logic [7:0] rst_cnt_q;
  wire busy = (st_q != swhpc_pkg::HST_IDLE);
  wire cmd_go = cmd_wr && (cmd_addr == swhpc_pkg::HR_CMD) && !busy;
  wire go_wr = cmd_go && cmd_wdata[swhpc_pkg::CMD_WRITE_BIT];
  wire go_rd = cmd_go && cmd_wdata[swhpc_pkg::CMD_READ_BIT] && !go_wr;
  wire go_rst = cmd_go && cmd_wdata[swhpc_pkg::CMD_RESET_BIT] && !go_wr && !go_rd;
  wire finish = (st_q == swhpc_pkg::HST_END);
  wire [15:0] stat_word = {14'h0000, done_q, busy};
  wire [15:0] rd_mux = (cmd_addr == swhpc_pkg::HR_ADDR) ? {1'b0, tgt_q} :
                       (cmd_addr == swhpc_pkg::HR_WDATA) ? wdata_q :
                       (cmd_addr == swhpc_pkg::HR_STAT) ? stat_word :
                       (cmd_addr == swhpc_pkg::HR_RDATA) ? rdata_q : 16'h0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgt_q <= 15'h0000;
      wdata_q <= 16'h0000;
      cmd_rdata <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      if (cmd_wr && cmd_addr == swhpc_pkg::HR_ADDR) begin
        tgt_q <= cmd_wdata[swhpc_pkg::ADDR_W-1:0];
      end
      if (cmd_wr && cmd_addr == swhpc_pkg::HR_WDATA) begin
        wdata_q <= cmd_wdata;
      end
      cmd_rdata <= cmd_rd ? rd_mux : 16'h0000;
      done_q <= finish || (done_q && !cmd_go);
    end
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= swhpc_pkg::HST_IDLE;
      rdata_q <= 16'h0000;
      rst_cnt_q <= 8'h00;
      bus.cs_n <= 1'b1;
      bus.ds_n <= 1'b1;
      bus.rw <= 1'b1;
      bus.addr <= 15'h0000;
      bus.host_data <= 16'h0000;
      bus.host_data_oe_n <= 1'b1;
      bus.reset_n <= 1'b1;
    end else begin
      unique case (st_q)
        swhpc_pkg::HST_IDLE: begin
          if (go_wr || go_rd) begin
            st_q <= swhpc_pkg::HST_SETUP;
            bus.addr <= tgt_q;
            bus.rw <= go_rd;
            bus.host_data <= wdata_q;
            bus.host_data_oe_n <= go_rd;
          end else if (go_rst) begin
            st_q <= swhpc_pkg::HST_RESET;
            bus.reset_n <= 1'b0;
            rst_cnt_q <= 8'(swhpc_pkg::RESET_CYC);
          end
        end
        swhpc_pkg::HST_SETUP: begin
          st_q <= swhpc_pkg::HST_STROBE;
          bus.cs_n <= 1'b0;
          bus.ds_n <= 1'b0;
        end
        swhpc_pkg::HST_STROBE: begin
          if (!bus.transfer_ack_n) begin
            st_q <= swhpc_pkg::HST_END;
            rdata_q <= bus.rw ? bus.host_data_bus : rdata_q;
            bus.cs_n <= 1'b1;
            bus.ds_n <= 1'b1;
          end
        end
        swhpc_pkg::HST_END: begin
          st_q <= swhpc_pkg::HST_IDLE;
          bus.host_data_oe_n <= 1'b1;
          bus.rw <= 1'b1;
        end
        swhpc_pkg::HST_RESET: begin
          rst_cnt_q <= rst_cnt_q - 8'h01;
          if (rst_cnt_q == 8'h01) begin
            st_q <= swhpc_pkg::HST_IDLE;
            bus.reset_n <= 1'b1;
          end
        end
        default: begin
          st_q <= swhpc_pkg::HST_IDLE;
        end
      endcase
    end
  end
endmodule : swhpc_host

// ==== verif/swhpc_asserts.sv ====
// concurrent checks on the processor port wires between host and device
module swhpc_asserts (
  // clock and reset
  input logic ref_clk,
  input logic rst,
  // host driven wires
  input logic cs_n,
  input logic ds_n,
  input logic rw,
  input logic host_data_oe_n,
  input logic reset_n,
  // device driven wires
  input logic dev_data_oe_n,
  input logic ack_out,
  input logic ack_oe_n,
  input logic transfer_ack_n
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // helpers
  // ****************************************
  wire ack_lo = !ack_oe_n && !ack_out;
  wire ack_hi = !ack_oe_n && ack_out;
  wire sel = !cs_n && !ds_n;

  // strobe released while acknowledging, then driven high
  sequence s_ack_end;
    (ack_lo && !sel && reset_n) ##1 ack_hi;
  endsequence

  chk_ack_cause: assert property (ack_lo |-> $past(sel))
    else $error("ack low without select and strobe");
  chk_ack_prompt: assert property ($fell(ds_n) && !cs_n && reset_n |=> ack_lo)
    else $error("ack not low one cycle after strobe");
  chk_ack_hold: assert property (ack_lo && sel && reset_n |=> ack_lo)
    else $error("ack dropped while strobe held");
  chk_ack_end: assert property (ack_lo && !sel && reset_n |=> ack_hi)
    else $error("ack not driven high after strobe release");
  chk_ack_release: assert property (s_ack_end |=> ack_oe_n && transfer_ack_n)
    else $error("ack not released after high step");
  chk_read_only: assert property (!dev_data_oe_n |-> rw && ack_lo)
    else $error("device drives data outside a read");
  chk_read_data: assert property (ack_lo && rw |-> !dev_data_oe_n)
    else $error("read acknowledged without data driven");
  chk_no_fight: assert property (!host_data_oe_n |-> dev_data_oe_n && !rw)
    else $error("both ends drive the data bus");
  chk_reset_float: assert property (!reset_n |=> ack_oe_n && dev_data_oe_n)
    else $error("outputs driven during device reset");
  chk_strobe_sel: assert property (!ds_n |-> !cs_n)
    else $error("strobe without chip select");
  chk_strobe_end: assert property (ack_lo && !sel && reset_n |=> dev_data_oe_n)
    else $error("read data held after strobe release");
endmodule : swhpc_asserts

// ==== verif/tb_switch_host_port_and_pin_control.sv ====
// self-checking bench joining host and device ends over the port interface
module tb_switch_host_port_and_pin_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] cmd_addr = 4'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] cmd_rdata;
  logic serial_clk = 1'b0;
  logic frame_sync_in = 1'b1;
  logic frame_measure_in = 1'b0;
  logic frame_format_select = 1'b0;
  logic tx_drive_enable = 1'b0;
  logic [31:0] serial_in_streams = 32'h00000000;
  logic [31:0] serial_out_streams;
  logic [31:0] serial_out_oe_n;
  logic wide_frame_pulse_mode;
  logic format_detected;
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h00000034;
  logic [15:0] mdl [int];
  logic [15:0] rd;
  logic [15:0] d;
  logic [31:0] exp_oe;
  logic [14:0] a;
  logic [31:0] rx;
  logic [31:0] exp_tx;
  logic [31:0] rxq [$];

  always #50 ref_clk = ~ref_clk;

  swhpc_bus_if bus();
  swhpc_host u_swhpc_host (.ref_clk(ref_clk), .rst(rst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .bus(bus));
  swhpc_dev u_swhpc_dev (.ref_clk(ref_clk), .rst(rst), .bus(bus), .serial_clk(serial_clk),
    .frame_sync_in(frame_sync_in), .frame_measure_in(frame_measure_in),
    .frame_format_select(frame_format_select), .tx_drive_enable(tx_drive_enable),
    .serial_in_streams(serial_in_streams), .serial_out_streams(serial_out_streams),
    .serial_out_oe_n(serial_out_oe_n), .wide_frame_pulse_mode(wide_frame_pulse_mode),
    .format_detected(format_detected));
  swhpc_asserts u_swhpc_asserts (.ref_clk(ref_clk), .rst(rst), .cs_n(bus.cs_n),
    .ds_n(bus.ds_n), .rw(bus.rw), .host_data_oe_n(bus.host_data_oe_n), .reset_n(bus.reset_n),
    .dev_data_oe_n(bus.dev_data_oe_n), .ack_out(bus.ack_out), .ack_oe_n(bus.ack_oe_n),
    .transfer_ack_n(bus.transfer_ack_n));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hw(input logic [3:0] ad, input logic [15:0] wd);
    cmd_addr <= ad;
    cmd_wdata <= wd;
    cmd_wr <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : hw

  task automatic hr(input logic [3:0] ad, output logic [15:0] q);
    cmd_addr <= ad;
    cmd_rd <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    @(negedge ref_clk);
    q = cmd_rdata;
    @(posedge ref_clk);
  endtask : hr

  // one device access through the host command registers
  task automatic acc(input logic rdn, input logic [14:0] ad, input logic [15:0] wd,
                     output logic [15:0] q);
    logic [15:0] s;
    int n;
    q = 16'h0000;
    s = 16'hFFFF;
    n = 0;
    hw(swhpc_pkg::HR_ADDR, {1'b0, ad});
    hw(swhpc_pkg::HR_WDATA, wd);
    hw(swhpc_pkg::HR_CMD, rdn ? 16'h0002 : 16'h0001);
    while (s[swhpc_pkg::HSTAT_BUSY_BIT] !== 1'b0 && n < 40) begin
      hr(swhpc_pkg::HR_STAT, s);
      n++;
    end
    chk({31'h0, s[swhpc_pkg::HSTAT_BUSY_BIT]}, 32'h0, "access never completed");
    if (rdn) hr(swhpc_pkg::HR_RDATA, q);
  endtask : acc

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (11) @(posedge ref_clk);
    chk({30'h0, bus.transfer_ack_n, bus.dev_data_oe_n}, 32'h3, "port float in reset");
    chk(serial_out_oe_n, 32'hFFFFFFFF, "streams float in reset");
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    hr(4'hF, rd);
    chk({16'h0, rd}, 32'h0, "unmapped host register");
    $display("reset test done");
    for (int s = 0; s < 32; s++) begin
      d = 16'(xorshift());
      if (s % 4 == 0) d = d | 16'hC000;
      if (s % 4 == 1) d = d & 16'h3FFF;
      a = {swhpc_pkg::REGION_CM, 8'h00, s[4:0]};
      acc(1'b0, a, d, rd);
      mdl[s] = d;
    end
    for (int s = 0; s < 32; s++) begin
      a = {swhpc_pkg::REGION_CM, 8'h00, s[4:0]};
      acc(1'b1, a, 16'h0000, rd);
      chk({16'h0, rd}, {16'h0, mdl[s]}, "connection memory read");
    end
    $display("memory access test done");
    for (int i = 0; i < 4; i++) begin
      tx_drive_enable <= i[1];
      acc(1'b0, {swhpc_pkg::REGION_CTRL, swhpc_pkg::CTRL_OFS}, {15'h0, i[0]}, rd);
      acc(1'b1, {swhpc_pkg::REGION_CTRL, swhpc_pkg::CTRL_OFS}, 16'h0000, rd);
      chk({31'h0, rd[swhpc_pkg::CTRL_OSB_BIT]}, {31'h0, i[0]}, "standby bit");
      repeat (3) @(posedge ref_clk);
      for (int s = 0; s < 32; s++)
        exp_oe[s] = (i == 0) || (mdl[s][15] && mdl[s][14]);
      chk(serial_out_oe_n, exp_oe, "stream float");
    end
    $display("drive enable test done");
    for (int i = 0; i < 2; i++) begin
      frame_format_select <= i[0];
      repeat (4) @(posedge ref_clk);
      acc(1'b1, {swhpc_pkg::REGION_CTRL, swhpc_pkg::STAT_OFS}, 16'h0000, rd);
      chk({31'h0, rd[swhpc_pkg::STAT_WIDE_BIT]}, {31'h0, i[0]}, "wide mode status");
      chk({31'h0, wide_frame_pulse_mode}, {31'h0, i[0]}, "wide mode pin");
    end
    $display("frame select test done");
    tx_drive_enable <= 1'b0;
    hw(swhpc_pkg::HR_CMD, 16'h0004);
    repeat (3) @(posedge ref_clk);
    chk(serial_out_oe_n, 32'hFFFFFFFF, "streams float after device reset");
    acc(1'b1, {swhpc_pkg::REGION_CTRL, swhpc_pkg::CTRL_OFS}, 16'h0000, rd);
    chk({16'h0, rd}, {16'h0, swhpc_pkg::CTRL_RESET}, "control after device reset");
    acc(1'b1, {swhpc_pkg::REGION_CM, 8'h00, 5'h05}, 16'h0000, rd);
    chk({16'h0, rd}, {16'h0, mdl[5]}, "memory kept over device reset");
    $display("device reset test done");
    rxq.push_back(serial_in_streams);
    for (int i = 0; i < 2; i++) begin
      frame_sync_in <= i[0];
      for (int k = 0; k < 24; k++) begin
        serial_clk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        if (i == 0 && k < 8) begin
          for (int s = 0; s < 32; s++) exp_tx[s] = mdl[s][7 - k];
          chk(serial_out_streams, exp_tx, "stream output bit");
        end
        serial_clk <= 1'b0;
        rx = xorshift();
        serial_in_streams <= rx;
        rxq.push_back(rx);
        frame_measure_in <= ~frame_measure_in;
        repeat (4) @(posedge ref_clk);
      end
      chk({31'h0, format_detected}, {31'h0, !i[0]}, "frame format detect");
      if (i == 0) begin
        for (int j = 0; j < 8; j++) exp_tx[7 - j] = rxq[8 + j][3];
        acc(1'b1, {swhpc_pkg::REGION_DM, 8'h01, 5'h03}, 16'h0000, rd);
        chk({16'h0, rd}, {24'h0, exp_tx[7:0]}, "data memory byte");
      end
    end
    $display("frame detect test done");
    results();
  end
endmodule : tb_switch_host_port_and_pin_control
